// ### rtl/rsfc_pkg.sv
package rsfc_pkg;
   // Clock and timing
   localparam int unsigned CLK_PERIOD_NS = 5; // System clock period
   localparam int unsigned HOLD_NS = 100; // Internal reset stretch time
   localparam int unsigned HOLD_CYC = (HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS; // Rounded up
   localparam int unsigned HOLD_W = 8; // Hold counter width
   localparam int unsigned WDT_TICK_DIV = 200; // Watchdog tick divider, cycles
   localparam int unsigned WDT_LIMIT = 1000; // Watchdog ticks to expiry

   ////////////////////////////////////////////////////////////////////////////////
   // Bus
   localparam int unsigned ADDR_W = 12; // APB address width
   localparam logic [11:0] ADDR_STATUS = 12'h000; // Status flags
   localparam logic [11:0] ADDR_CTL_BASE = 12'h004; // First control register
   localparam logic [11:0] ADDR_STACK = 12'h040; // Stack pointer, read only
   localparam logic [11:0] ADDR_EVT = 12'h044; // Event status, write one to clear
   localparam logic [11:0] ADDR_MASK = 12'h048; // Event mask
   localparam logic [11:0] ADDR_PRESC = 12'h04c; // Timer prescaler count
   localparam logic [4:0] WORD_LAST = 5'h13; // Highest mapped word

   ////////////////////////////////////////////////////////////////////////////////
   // Control registers, index order
   localparam int unsigned NCTL = 15; // Number of control registers
   localparam int unsigned CTL_PCL = 0; // program_counter_low
   localparam int unsigned CTL_IRQ_CONTROL_0 = 1; // irq_control_0
   localparam int unsigned CTL_TIMER_CONTROL = 2; // timer_control
   localparam int unsigned CTL_PA = 3; // port_a_data
   localparam int unsigned CTL_PAC = 4; // port_a_direction
   localparam int unsigned CTL_MODE = 12; // clock_mode_select
   // Reset values, index 14 first
   localparam logic [NCTL-1:0][7:0] CTL_RST = {8'h10, 8'h40, 8'h00, 8'h00, 8'h00, 8'hff, 8'hff, 8'h00,
      8'hff, 8'hff, 8'hff, 8'hff, 8'h08, 8'h00, 8'h00};
   // Implemented bits, index 14 first
   localparam logic [NCTL-1:0][7:0] CTL_MASK = {8'hff, 8'hff, 8'h03, 8'h3f, 8'h03, 8'hff, 8'hff, 8'hff,
      8'hff, 8'hff, 8'hff, 8'hff, 8'hdf, 8'h7f, 8'hff};

   ////////////////////////////////////////////////////////////////////////////////
   // Fields
   localparam int unsigned STAT_WDT_BIT = 0; // watchdog_expiry_flag
   localparam int unsigned STAT_PDF_BIT = 1; // powerdown_flag
   localparam int unsigned MODE_SLOW_BIT = 0; // slow_clock_select
   localparam int unsigned TIMER_CONTROL_ON_BIT = 4; // Timer run enable
   localparam int unsigned RC_PIN_BIT = 6; // port_a_bit6, shared with rc_oscillator_input
   localparam int unsigned SP_W = 3; // Stack pointer width
   localparam logic [2:0] SP_TOP = 3'h0; // Top of stack
   localparam int unsigned EVT_W = 4; // Event bits
   localparam int unsigned EVT_PIN = 0; // Pin reset
   localparam int unsigned EVT_LVR = 1; // Undervoltage reset
   localparam int unsigned EVT_WDT_RUN = 2; // Watchdog reset while running
   localparam int unsigned EVT_WDT_HALT = 3; // Watchdog wake from power-down

   // Sequencer states, Gray along idle-hold-release
   typedef enum logic [1:0] {
      RSFC_IDLE = 2'b00,
      RSFC_HOLD = 2'b01,
      RSFC_REL = 2'b11
   } rsfc_state_t;

   // Reset causes
   typedef enum logic [1:0] {
      RSFC_POWERON = 2'b00,
      RSFC_PIN = 2'b01,
      RSFC_WDT_RUN = 2'b11,
      RSFC_WDT_HALT = 2'b10
   } rsfc_cause_t;
endpackage : rsfc_pkg

// ### rtl/rsfc_watchdog.sv
`timescale 1ns/100ps
module rsfc_watchdog #(
   parameter int unsigned TICK_DIV = rsfc_pkg::WDT_TICK_DIV,
   parameter int unsigned LIMIT = rsfc_pkg::WDT_LIMIT
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic clear, // Restart count
   output logic expiry_q // One-cycle expiry pulse
);
   // All watchdog state
   typedef struct packed {
      logic [15:0] div; // Tick divider
      logic [15:0] cnt; // Tick count
      logic expiry; // Expiry pulse
   } rsfc_wdt_t;

   rsfc_wdt_t s_q;
   rsfc_wdt_t s_d;

   ////////////////////////////////////////////////////////////////////////////////
   // Next state
   always_comb begin
      s_d = s_q;
      s_d.expiry = 1'b0;
      if (clear) begin
         // Cleared, counting resumes next cycle
         s_d.div = 16'h0000;
         s_d.cnt = 16'h0000;
      end else if (s_q.div == 16'(TICK_DIV - 1)) begin
         // Tick enable
         s_d.div = 16'h0000;
         if (s_q.cnt == 16'(LIMIT - 1)) begin
            s_d.cnt = 16'h0000;
            s_d.expiry = 1'b1;
         end else begin
            s_d.cnt = s_q.cnt + 16'h0001;
         end
      end else begin
         s_d.div = s_q.div + 16'h0001;
      end
   end

   // State register; counts from power-on release
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign expiry_q = s_q.expiry;
endmodule : rsfc_watchdog

// ### rtl/rsfc_top.sv
// Functional notes
// - Halted watchdog wake clears program counter, stack
// - Power-on reset reads both flags zero
// - Pin or undervoltage reset keeps both flags
// - Running watchdog reset sets expiry flag
// - Halted watchdog wake leaves both flags one
// - Power-on disables interrupts, zeroes program counter
// - Watchdog cleared at power-on, counts at once
// - Power-on switches timer off
// - Power-on clears timer prescaler
// - Power-on makes every port pin input
// - Power-on puts stack pointer at top
// - Full resets load defaults; halted wake only counter and stack
// - Mode bit selects slow clock; oscillator strapped
// - RC option takes port A bit6 only
// - Halt sets powerdown flag, clears expiry flag
// - Clear-watchdog clears powerdown flag
`timescale 1ns/100ps
module rsfc_top #(
   parameter int unsigned WDT_TICK_DIV = rsfc_pkg::WDT_TICK_DIV,
   parameter int unsigned WDT_LIMIT = rsfc_pkg::WDT_LIMIT
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [rsfc_pkg::ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic external_clear_input, // Pin reset request pulse
   input wire logic undervoltage_clear, // Undervoltage reset request pulse
   input wire logic halt_exec, // Halt instruction executed
   input wire logic clear_watchdog_exec, // Clear-watchdog instruction executed
   input wire logic rc_osc_option, // Main oscillator is external RC
   output logic core_reset_q,
   output logic slow_clock_q,
   output logic rc_oscillator_input_q,
   output logic [7:0] port_a_out_q,
   output logic [7:0] port_a_oe_q,
   output logic irq_q
);
   // All block state
   typedef struct packed {
      rsfc_pkg::rsfc_state_t st; // Sequencer state
      rsfc_pkg::rsfc_cause_t cause; // Pending reset cause
      logic [rsfc_pkg::HOLD_W-1:0] cnt; // Hold counter
      logic core_rst; // Internal reset
      logic halted; // Power-down mode
      logic wdt_flag; // watchdog_expiry_flag
      logic powerdown_flag; // powerdown_flag
      logic [rsfc_pkg::SP_W-1:0] sp; // Stack pointer
      logic [rsfc_pkg::NCTL-1:0][7:0] ctl; // Control registers
      logic [rsfc_pkg::EVT_W-1:0] evt; // Event status
      logic [rsfc_pkg::EVT_W-1:0] mask; // Event mask
      logic [7:0] presc; // Timer prescaler
      logic irq; // Interrupt
      logic pready; // Access phase ready
      logic pslverr; // Unmapped access
      logic [31:0] prdata; // Read data
      logic slow; // Slow clock select out
      logic rc_pin; // Bit6 used as oscillator
      logic [7:0] pa_out; // Port A pin drive
      logic [7:0] pa_oe; // Port A enables
   } rsfc_state_s_t;

   rsfc_state_s_t s_q;
   rsfc_state_s_t s_d;
   logic wdt_expiry; // Watchdog expiry pulse
   logic wdt_clear; // Watchdog restart

   ////////////////////////////////////////////////////////////////////////////////
   // Helpers

   // Word index of a byte address
   function automatic logic [4:0] rsfc_word(input logic [rsfc_pkg::ADDR_W-1:0] a);
      rsfc_word = a[6:2];
   endfunction : rsfc_word

   // Address maps onto a register
   function automatic logic rsfc_hit(input logic [rsfc_pkg::ADDR_W-1:0] a);
      rsfc_hit = (a[1:0] == 2'b00) && (a[rsfc_pkg::ADDR_W-1:7] == '0) && (a[6:2] <= rsfc_pkg::WORD_LAST);
   endfunction : rsfc_hit

   // Control register index of a word
   function automatic logic [3:0] rsfc_ctl_idx(input logic [4:0] w);
      rsfc_ctl_idx = 4'(w - rsfc_word(rsfc_pkg::ADDR_CTL_BASE));
   endfunction : rsfc_ctl_idx

   // Word falls in the control block
   function automatic logic rsfc_is_ctl(input logic [4:0] w);
      rsfc_is_ctl = (w >= rsfc_word(rsfc_pkg::ADDR_CTL_BASE)) && (w < rsfc_word(rsfc_pkg::ADDR_STACK));
   endfunction : rsfc_is_ctl

   ////////////////////////////////////////////////////////////////////////////////
   // Watchdog counter
   rsfc_watchdog #(
      .TICK_DIV(WDT_TICK_DIV),
      .LIMIT(WDT_LIMIT)
   ) u_wdt (
      .pclk(pclk),
      .presetn(presetn),
      .clear(wdt_clear),
      .expiry_q(wdt_expiry)
   );

   // Restart on instruction, halt, or any reset release
   assign wdt_clear = clear_watchdog_exec | halt_exec | (s_q.st == rsfc_pkg::RSFC_REL);

   ////////////////////////////////////////////////////////////////////////////////
   // Next state
   always_comb begin
      logic [4:0] w;
      logic [3:0] ci;
      logic wr;
      logic [rsfc_pkg::EVT_W-1:0] ev_set;
      w = rsfc_word(paddr);
      ci = rsfc_ctl_idx(w);
      wr = psel & penable & s_q.pready & pwrite;
      ev_set = '0;
      s_d = s_q;
      s_d.pready = 1'b0;
      s_d.pslverr = 1'b0;

      // Bus setup phase: latch read data, answer next cycle
      if (psel && !penable && !s_q.pready) begin
         s_d.pready = 1'b1;
         s_d.pslverr = !rsfc_hit(paddr);
         s_d.prdata = 32'h0000_0000;
         if (rsfc_hit(paddr) && !pwrite) begin
            if (w == rsfc_word(rsfc_pkg::ADDR_STATUS)) begin
               // Flags
               s_d.prdata[rsfc_pkg::STAT_WDT_BIT] = s_q.wdt_flag;
               s_d.prdata[rsfc_pkg::STAT_PDF_BIT] = s_q.powerdown_flag;
            end else if (rsfc_is_ctl(w)) begin
               // Control block
               s_d.prdata[7:0] = s_q.ctl[ci];
            end else if (w == rsfc_word(rsfc_pkg::ADDR_STACK)) begin
               s_d.prdata[rsfc_pkg::SP_W-1:0] = s_q.sp;
            end else if (w == rsfc_word(rsfc_pkg::ADDR_EVT)) begin
               s_d.prdata[rsfc_pkg::EVT_W-1:0] = s_q.evt;
            end else if (w == rsfc_word(rsfc_pkg::ADDR_MASK)) begin
               s_d.prdata[rsfc_pkg::EVT_W-1:0] = s_q.mask;
            end else begin
               // Prescaler count
               s_d.prdata[7:0] = s_q.presc;
            end
         end
      end

      // Bus write at completing access edge
      if (wr && rsfc_hit(paddr) && pstrb[0]) begin
         if (rsfc_is_ctl(w)) begin
            s_d.ctl[ci] = pwdata[7:0] & rsfc_pkg::CTL_MASK[ci];
         end else if (w == rsfc_word(rsfc_pkg::ADDR_EVT)) begin
            // Write one to clear
            s_d.evt = s_q.evt & ~pwdata[rsfc_pkg::EVT_W-1:0];
         end else if (w == rsfc_word(rsfc_pkg::ADDR_MASK)) begin
            s_d.mask = pwdata[rsfc_pkg::EVT_W-1:0];
         end
      end

      // Instruction effects, only while running
      if (s_q.st == rsfc_pkg::RSFC_IDLE) begin
         if (clear_watchdog_exec) begin
            s_d.powerdown_flag = 1'b0;
         end
         if (halt_exec) begin
            // Enter power-down; set beats clear
            s_d.powerdown_flag = 1'b1;
            s_d.wdt_flag = 1'b0;
            s_d.halted = 1'b1;
         end
      end

      // Timer prescaler runs only when timer enabled
      if (!s_q.core_rst && s_q.ctl[rsfc_pkg::CTL_TIMER_CONTROL][rsfc_pkg::TIMER_CONTROL_ON_BIT]) begin
         s_d.presc = s_q.presc + 8'h01;
      end

      // Reset sequencer
      case (s_q.st)
         rsfc_pkg::RSFC_IDLE: begin
            if (external_clear_input || undervoltage_clear) begin
               // Pin or undervoltage, awake or halted
               s_d.cause = rsfc_pkg::RSFC_PIN;
               s_d.st = rsfc_pkg::RSFC_HOLD;
               s_d.cnt = '0;
               s_d.core_rst = 1'b1;
               ev_set[rsfc_pkg::EVT_PIN] = external_clear_input;
               ev_set[rsfc_pkg::EVT_LVR] = undervoltage_clear;
            end else if (wdt_expiry) begin
               // Watchdog, kind chosen by power-down mode
               s_d.cause = s_q.halted ? rsfc_pkg::RSFC_WDT_HALT : rsfc_pkg::RSFC_WDT_RUN;
               s_d.st = rsfc_pkg::RSFC_HOLD;
               s_d.cnt = '0;
               s_d.core_rst = 1'b1;
               ev_set[rsfc_pkg::EVT_WDT_HALT] = s_q.halted;
               ev_set[rsfc_pkg::EVT_WDT_RUN] = !s_q.halted;
            end
         end
         rsfc_pkg::RSFC_HOLD: begin
            // Stretch internal reset
            s_d.cnt = s_q.cnt + 1'b1;
            if (s_q.cnt == rsfc_pkg::HOLD_W'(rsfc_pkg::HOLD_CYC - 1)) begin
               s_d.st = rsfc_pkg::RSFC_REL;
            end
         end
         rsfc_pkg::RSFC_REL: begin
            // Apply cause effects in the release cycle
            s_d.st = rsfc_pkg::RSFC_IDLE;
            s_d.core_rst = 1'b0;
            s_d.halted = 1'b0;
            case (s_q.cause)
               rsfc_pkg::RSFC_WDT_HALT: begin
                  // Only counter and stack move
                  s_d.ctl[rsfc_pkg::CTL_PCL] = 8'h00;
                  s_d.sp = '0;
                  s_d.wdt_flag = 1'b1;
               end
               rsfc_pkg::RSFC_WDT_RUN: begin
                  s_d.ctl = rsfc_pkg::CTL_RST;
                  s_d.sp = rsfc_pkg::SP_TOP;
                  s_d.presc = 8'h00;
                  s_d.wdt_flag = 1'b1;
               end
               rsfc_pkg::RSFC_POWERON: begin
                  s_d.ctl = rsfc_pkg::CTL_RST;
                  s_d.sp = rsfc_pkg::SP_TOP;
                  s_d.presc = 8'h00;
                  s_d.wdt_flag = 1'b0;
                  s_d.powerdown_flag = 1'b0;
               end
               default: begin
                  // Pin or undervoltage, flags untouched
                  s_d.ctl = rsfc_pkg::CTL_RST;
                  s_d.sp = rsfc_pkg::SP_TOP;
                  s_d.presc = 8'h00;
               end
            endcase
         end
         default: begin
            s_d.st = rsfc_pkg::RSFC_IDLE;
         end
      endcase

      // Events set after clears, so set wins
      s_d.evt = s_d.evt | ev_set;
      s_d.irq = |(s_d.evt & s_d.mask);

      // Clock select and pin sharing
      s_d.slow = s_d.ctl[rsfc_pkg::CTL_MODE][rsfc_pkg::MODE_SLOW_BIT];
      s_d.rc_pin = rc_osc_option;
      s_d.pa_out = s_d.ctl[rsfc_pkg::CTL_PA];
      s_d.pa_oe = ~s_d.ctl[rsfc_pkg::CTL_PAC]; // Direction one means input
      if (rc_osc_option) begin
         // Bit6 becomes oscillator input, bit5 stays normal I/O
         s_d.pa_out[rsfc_pkg::RC_PIN_BIT] = 1'b0;
         s_d.pa_oe[rsfc_pkg::RC_PIN_BIT] = 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // State register; power-on starts held in reset
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_q <= '0;
         s_q.st <= rsfc_pkg::RSFC_HOLD;
         s_q.cause <= rsfc_pkg::RSFC_POWERON;
         s_q.core_rst <= 1'b1;
         s_q.ctl <= rsfc_pkg::CTL_RST;
         s_q.sp <= rsfc_pkg::SP_TOP;
         s_q.pa_out <= 8'hff;
      end else begin
         s_q <= s_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Outputs straight from state
   assign prdata = s_q.prdata;
   assign pready = s_q.pready;
   assign pslverr = s_q.pslverr;
   assign core_reset_q = s_q.core_rst;
   assign slow_clock_q = s_q.slow;
   assign rc_oscillator_input_q = s_q.rc_pin;
   assign port_a_out_q = s_q.pa_out;
   assign port_a_oe_q = s_q.pa_oe;
   assign irq_q = s_q.irq;
endmodule : rsfc_top

// ### test/rsfc_properties.sv
`timescale 1ns/100ps
module rsfc_checker #(
   parameter int unsigned WDT_TICK_DIV = rsfc_pkg::WDT_TICK_DIV,
   parameter int unsigned WDT_LIMIT = rsfc_pkg::WDT_LIMIT
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [rsfc_pkg::ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic external_clear_input,
   input wire logic undervoltage_clear,
   input wire logic halt_exec,
   input wire logic clear_watchdog_exec,
   input wire logic rc_osc_option,
   input wire logic core_reset_q,
   input wire logic slow_clock_q,
   input wire logic rc_oscillator_input_q,
   input wire logic [7:0] port_a_out_q,
   input wire logic [7:0] port_a_oe_q,
   input wire logic irq_q
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   ////////////////////////////////////////////////////////////////////////////////
   // Bus phases
   sequence s_setup;
      psel && !penable;
   endsequence
   sequence s_done;
      psel && penable && pready;
   endsequence
   // Write of clock mode word while core runs
   sequence s_mode_wr;
      s_done ##0 (pwrite && pstrb[0] && paddr == 12'h034 && !core_reset_q);
   endsequence
   ////////////////////////////////////////////////////////////////////////////////
   property p_answer; s_setup |=> pready; endproperty
   a_answer: assert property (p_answer) else $error("no answer one cycle after setup");
   property p_ready_phase; pready |-> psel && penable; endproperty
   a_ready_phase: assert property (p_ready_phase) else $error("ready outside access phase");
   property p_ready_pulse; pready |=> !pready; endproperty
   a_ready_pulse: assert property (p_ready_pulse) else $error("ready longer than one cycle");
   property p_err_with_ready; pslverr |-> pready; endproperty
   a_err_with_ready: assert property (p_err_with_ready) else $error("error without ready");
   property p_upper_zero; s_done ##0 !pwrite |-> prdata[31:8] == 24'h0; endproperty
   a_upper_zero: assert property (p_upper_zero) else $error("read data upper bytes not zero");
   property p_bad_addr; s_setup ##0 (paddr[1:0] != 2'h0 || paddr > 12'h04c) |=> pslverr; endproperty
   a_bad_addr: assert property (p_bad_addr) else $error("bad address not refused");
   property p_slow; s_mode_wr |=> slow_clock_q == $past(pwdata[0]); endproperty
   a_slow: assert property (p_slow) else $error("slow clock select not following mode write");
   property p_rc_pin;
      rc_osc_option && $past(rc_osc_option) && $past(rc_osc_option, 2) && !core_reset_q && !$past(core_reset_q)
         |-> !port_a_oe_q[6] && !port_a_out_q[6];
   endproperty
   a_rc_pin: assert property (p_rc_pin) else $error("shared oscillator pin still driven");
   property p_req; (external_clear_input || undervoltage_clear) && !core_reset_q |=> core_reset_q; endproperty
   a_req: assert property (p_req) else $error("reset request not taken");
   property p_hold; $rose(core_reset_q) |-> core_reset_q [*8] ##[10:25] !core_reset_q; endproperty
   a_hold: assert property (p_hold) else $error("internal reset length wrong");
endmodule : rsfc_checker
bind rsfc_top rsfc_checker #(.WDT_TICK_DIV(WDT_TICK_DIV), .WDT_LIMIT(WDT_LIMIT)) u_chk (.pclk(pclk),
   .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
   .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr), .external_clear_input(external_clear_input),
   .undervoltage_clear(undervoltage_clear), .halt_exec(halt_exec), .clear_watchdog_exec(clear_watchdog_exec),
   .rc_osc_option(rc_osc_option), .core_reset_q(core_reset_q), .slow_clock_q(slow_clock_q),
   .rc_oscillator_input_q(rc_oscillator_input_q), .port_a_out_q(port_a_out_q), .port_a_oe_q(port_a_oe_q),
   .irq_q(irq_q));

// ### test/test_reset_state_and_flag_control.sv
`timescale 1ns/100ps
module test_reset_state_and_flag_control;
   // Expected bus result
   typedef struct packed {logic wr; logic err; logic [11:0] addr; logic [31:0] data;} rsfc_exp_t;
   logic pclk, presetn, psel, penable, pwrite, rc, pready, pslverr, core_reset_q, slow_q, rcin_q, irq_q;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [3:0] pstrb, req; // Requests: pin, undervoltage, halt, clear watchdog
   logic [7:0] pa_out, pa_oe;
   logic [7:0] vals [15]; // Values written to control words
   int miscompares = 0, checked = 0, seed = 73;
   rsfc_exp_t expq [$]; // Notes of expected results
   rsfc_exp_t e;
   ////////////////////////////////////////////////////////////////////////////////
   // Short watchdog: expiry after 1000 cycles
   rsfc_top #(.WDT_TICK_DIV(4), .WDT_LIMIT(250)) uut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .external_clear_input(req[0]), .undervoltage_clear(req[1]),
      .halt_exec(req[2]), .clear_watchdog_exec(req[3]), .rc_osc_option(rc), .core_reset_q(core_reset_q),
      .slow_clock_q(slow_q), .rc_oscillator_input_q(rcin_q), .port_a_out_q(pa_out), .port_a_oe_q(pa_oe),
      .irq_q(irq_q));
   // Clock
   initial begin
      pclk = 1'b0;
      forever #2.5 pclk = ~pclk;
   end
   ////////////////////////////////////////////////////////////////////////////////
   // Compare and count
   task cmp(string n, logic [31:0] x, logic [31:0] s);
      checked++;
      if (s !== x) begin
         $display("MISMATCH %s expected %h seen %h", n, x, s);
         miscompares++;
      end
   endtask : cmp
   // Verdict and stop
   task end_of_test;
      repeat (4) @(posedge pclk);
      $display("checked %0d miscompares %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : end_of_test
   // One bus transfer, expectation noted first
   task apb(logic w, logic [11:0] a, logic [31:0] d, logic er, logic [31:0] x);
      int n;
      expq.push_back('{w, er, a, x});
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 20) begin
         miscompares++;
         end_of_test();
      end
   endtask : apb
   task wr(logic [11:0] a, logic [31:0] d);
      apb(1'b1, a, d, 1'b0, 32'h0);
   endtask : wr
   task rd(logic [11:0] a, logic [31:0] x);
      apb(1'b0, a, 32'h0, 1'b0, x);
   endtask : rd
   function automatic logic [11:0] ctl(int i);
      return rsfc_pkg::ADDR_CTL_BASE + 12'(4 * i);
   endfunction : ctl
   // One-cycle request pulse
   task pulse(int k);
      @(posedge pclk);
      req[k] <= 1'b1;
      @(posedge pclk);
      req[k] <= 1'b0;
   endtask : pulse
   // Internal reset rises and falls within bound
   task wait_rst(int lim);
      int n;
      n = 0;
      while (core_reset_q !== 1'b1 && n < lim) begin
         @(posedge pclk);
         n++;
      end
      while (core_reset_q !== 1'b0 && n < lim + 100) begin
         @(posedge pclk);
         n++;
      end
      if (core_reset_q !== 1'b0) begin
         miscompares++;
         end_of_test();
      end
   endtask : wait_rst
   ////////////////////////////////////////////////////////////////////////////////
   // Watch completed transfers, oldest note first
   always @(posedge pclk) begin
      if (psel && penable && pready === 1'b1 && expq.size() > 0) begin
         e = expq.pop_front();
         cmp("pslverr", {31'h0, e.err}, {31'h0, pslverr});
         if (!e.wr) cmp($sformatf("read %h", e.addr), e.data, prdata);
      end
   end
   // Hang guard
   initial begin
      repeat (20000) @(posedge pclk);
      miscompares++;
      end_of_test();
   end
   ////////////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      {psel, penable, pwrite, rc, presetn} = 5'h0;
      paddr = 12'h0;
      pwdata = 32'h0;
      pstrb = 4'hf;
      req = 4'h0;
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      wait_rst(100);
      rd(rsfc_pkg::ADDR_STATUS, 32'h0);
      for (int i = 0; i < 15; i++) rd(ctl(i), {24'h0, rsfc_pkg::CTL_RST[i]});
      rd(rsfc_pkg::ADDR_STACK, 32'h0);
      rd(rsfc_pkg::ADDR_PRESC, 32'h0);
      cmp("port oe", 32'h0, {24'h0, pa_oe});
      apb(1'b0, 12'h050, 32'h0, 1'b1, 32'h0);
      apb(1'b1, 12'h006, 32'h5, 1'b1, 32'h0);
      wr(rsfc_pkg::ADDR_STATUS, 32'h3);
      rd(rsfc_pkg::ADDR_STATUS, 32'h0);
      for (int i = 0; i < 15; i++) begin
         vals[i] = 8'($random(seed));
         wr(ctl(i), {24'h0, vals[i]});
      end
      for (int i = 0; i < 15; i++) rd(ctl(i), {24'h0, vals[i] & rsfc_pkg::CTL_MASK[i]});
      cmp("slow clock", {31'h0, vals[12][0]}, {31'h0, slow_q});
      cmp("port oe", {24'h0, ~vals[4]}, {24'h0, pa_oe});
      rc <= 1'b1;
      repeat (3) @(posedge pclk);
      cmp("rc oe", {24'h0, ~vals[4] & 8'hbf}, {24'h0, pa_oe});
      cmp("rc out", {24'h0, vals[3] & 8'hbf}, {24'h0, pa_out});
      cmp("rc strap", 32'h1, {31'h0, rcin_q});
      rc <= 1'b0;
      $display("power-on and register test done");
      wait_rst(1100);
      rd(rsfc_pkg::ADDR_STATUS, 32'h1);
      for (int i = 0; i < 15; i++) rd(ctl(i), {24'h0, rsfc_pkg::CTL_RST[i]});
      rd(rsfc_pkg::ADDR_EVT, 32'h4);
      wr(rsfc_pkg::ADDR_MASK, 32'h4);
      repeat (2) @(posedge pclk);
      cmp("irq", 32'h1, {31'h0, irq_q});
      wr(rsfc_pkg::ADDR_MASK, 32'h0);
      repeat (2) @(posedge pclk);
      cmp("irq masked", 32'h0, {31'h0, irq_q});
      wr(rsfc_pkg::ADDR_MASK, 32'h4);
      wr(rsfc_pkg::ADDR_EVT, 32'h4);
      repeat (2) @(posedge pclk);
      cmp("irq cleared", 32'h0, {31'h0, irq_q});
      rd(rsfc_pkg::ADDR_EVT, 32'h0);
      $display("running watchdog test done");
      pulse(3);
      wr(ctl(rsfc_pkg::CTL_TIMER_CONTROL), 32'h18);
      pulse(0);
      pulse(1);
      wait_rst(50);
      rd(rsfc_pkg::ADDR_STATUS, 32'h1);
      rd(ctl(rsfc_pkg::CTL_TIMER_CONTROL), 32'h8);
      rd(rsfc_pkg::ADDR_EVT, 32'h1);
      wr(rsfc_pkg::ADDR_EVT, 32'h1);
      pulse(1);
      wait_rst(50);
      rd(rsfc_pkg::ADDR_EVT, 32'h2);
      wr(rsfc_pkg::ADDR_EVT, 32'h2);
      rd(rsfc_pkg::ADDR_STATUS, 32'h1);
      $display("pin and undervoltage test done");
      pulse(3);
      wr(ctl(rsfc_pkg::CTL_PAC), 32'h0f);
      wr(ctl(rsfc_pkg::CTL_PCL), 32'h55);
      pulse(2);
      rd(rsfc_pkg::ADDR_STATUS, 32'h2);
      repeat (1100) @(posedge pclk);
      rd(rsfc_pkg::ADDR_STATUS, 32'h3);
      rd(ctl(rsfc_pkg::CTL_PCL), 32'h0);
      rd(ctl(rsfc_pkg::CTL_PAC), 32'h0f);
      rd(rsfc_pkg::ADDR_STACK, 32'h0);
      rd(rsfc_pkg::ADDR_EVT, 32'h8);
      pulse(3);
      rd(rsfc_pkg::ADDR_STATUS, 32'h1);
      $display("halt and wake test done");
      end_of_test();
   end
endmodule : test_reset_state_and_flag_control
